// *** phy_dsp_pkg.sv ***
package phy_dsp_pkg;

  // Register offsets.
  localparam logic [15:0] SPARE_OFFSET = 16'h0308;
  localparam logic [15:0] DAC0_OFFSET = 16'h030B;
  localparam logic [15:0] DAC1_OFFSET = 16'h030C;
  localparam logic [15:0] DSP0_OFFSET = 16'h030F;
  localparam logic [15:0] DSP2_OFFSET = 16'h0311;
  localparam logic [15:0] DSP4_OFFSET = 16'h0313;
  localparam logic [15:0] DSP13_OFFSET = 16'h031C;

  // Reset values of the stored bits.
  localparam logic [15:0] SPARE_RESET = 16'h0000;
  localparam logic [15:0] DAC0_RESET = 16'h0C00;
  localparam logic [15:0] DAC1_RESET = 16'h0020;
  localparam logic [15:0] DSP0_RESET = 16'h0464;
  localparam logic [15:0] DSP2_RESET = 16'h01FC;
  localparam logic [15:0] DSP4_RESET = 16'h06F8;
  localparam logic [15:0] DSP13_RESET = 16'h1101;

  // Writable bits of each register; all others read as zero, except spare bits 0 and 1 (pin status, revision).
  localparam logic [15:0] SPARE_WMASK = 16'hFFFC;
  localparam logic [15:0] DAC0_WMASK = 16'h0FFF;
  localparam logic [15:0] DAC1_WMASK = 16'h003F;
  localparam logic [15:0] DSP0_WMASK = 16'h07FF;
  localparam logic [15:0] DSP2_WMASK = 16'hE1FE;
  localparam logic [15:0] DSP4_WMASK = 16'hFFFF;
  localparam logic [15:0] DSP13_WMASK = 16'hFFFF;

  // Spare register fields.
  localparam int SP_PIN_STATUS_BIT = 0;
  localparam int SP_REVISION_BIT = 1;
  localparam int SP_RMII_CLK_SEL_BIT = 2;
  localparam int SP_RXDIS_FREEZE_BIT = 4;
  localparam int SP_MSE_BYPASS_BIT = 5;
  localparam int SP_STEADY_FREEZE_BIT = 6;
  localparam int SP_COUNT_FREEZE_BIT = 7;
  localparam int SP_TIMER_LONG_BIT = 8;
  localparam int SP_WAIT_FREEZE_LSB = 10;

  // Transmit DAC fields.
  localparam int DAC_LEVEL_W = 6;
  localparam int DAC_MINUS_LSB = 6;
  localparam int DAC_ZERO_LSB = 0;
  localparam int DAC_PLUS_LSB = 0;

  // Equalizer sequence fields.
  localparam int TC_SEL_LSB = 8;
  localparam int TC_SEL_W = 3;
  localparam int FIRST_FREEZE_BIT = 7;
  localparam int SECOND_FREEZE_BIT = 6;
  localparam int THIRD_FREEZE_BIT = 5;
  localparam int CHECK_EN_LSB = 2;
  localparam int CHECK_EN_W = 3;
  localparam int FREQACC_CLR_BIT = 1;
  localparam int DFE_RESET_BIT = 0;

  // Gain and equalizer mode fields.
  localparam int CAGC_LSB = 14;
  localparam int CAGC_W = 2;
  localparam int COEFF_SEL_BIT = 13;
  localparam int COEFF_W = 8;
  localparam int COEFF0_SHORT_LSB = 1;
  localparam int COEFF0_LONG_LSB = 8;
  localparam int COEFF1_SHORT_LSB = 0;

  // Timing loop fields.
  localparam int KP_FORCE_EN_BIT = 15;
  localparam int KF_FORCE_EN_BIT = 14;
  localparam int KP_VAL_LSB = 11;
  localparam int KP_W = 3;
  localparam int KF_VAL_LSB = 7;
  localparam int KF_W = 4;
  localparam int KP_FREEZE_EN_BIT = 6;
  localparam int KP_FREEZE_VAL_BIT = 5;
  localparam int KF_FREEZE_EN_BIT = 4;
  localparam int KF_FREEZE_VAL_BIT = 3;
  localparam int PD_POL_BIT = 2;
  localparam int ENERGY_SEL_BIT = 1;
  localparam int PRECURSOR_EN_BIT = 0;

  // Adaptive loops in freeze order.
  localparam int LOOP_FINE_GAIN = 0;
  localparam int LOOP_FFE = 1;
  localparam int LOOP_DFE = 2;
  localparam int LOOP_KP = 3;
  localparam int LOOP_KF = 4;
  localparam int LOOP_DC = 5;
  localparam int LOOP_COUNT = 6;

  // Refresh freeze timers.
  localparam int CLK_PERIOD_NS = 4;
  localparam int TIMER_SHORT_US = 176;
  localparam int TIMER_LONG_US = 192;
  localparam int TIMER_SHORT_CYCLES = TIMER_SHORT_US * 1000 / CLK_PERIOD_NS;
  localparam int TIMER_LONG_CYCLES = TIMER_LONG_US * 1000 / CLK_PERIOD_NS;
  localparam int TIMER_W = 16;

  typedef enum logic [3:0] {
    SEQ_IDLE = 4'h0,
    SEQ_FFE1 = 4'h1,
    SEQ_FFE2 = 4'h2,
    SEQ_FFE3 = 4'h3,
    SEQ_DEQ_SWEEP = 4'h4,
    SEQ_STEADY = 4'h5,
    SEQ_LPI_FREEZE = 4'h6,
    SEQ_LPI_WAKE = 4'h7,
    SEQ_LPI_WAIT = 4'h8,
    SEQ_LPI_REFRESH = 4'h9
  } seq_state_type;

  typedef enum logic [1:0] {
    MLT3_ZERO = 2'b00,
    MLT3_PLUS = 2'b01,
    MLT3_MINUS = 2'b10
  } mlt3_type;

  typedef enum logic [1:0] {
    CNT_IDLE = 2'b00,
    CNT_RUN = 2'b01,
    CNT_DONE = 2'b10
  } cnt_state_type;

endpackage : phy_dsp_pkg

// *** rx_ctl_if.sv ***
`timescale 1ns/1ns
interface rx_ctl_if;
  import phy_dsp_pkg::*;
  logic [15:0] spare;
  seq_state_type seq_state;
  logic rx_disabled;
  logic lpi_entry_pending;
  logic counter_freeze;
  logic [LOOP_COUNT-1:0] freeze;
  logic mse_bypass;
  modport bank (
    output spare, seq_state, rx_disabled, lpi_entry_pending, counter_freeze,
    input freeze, mse_bypass
  );
  modport decode (
    input spare, seq_state, rx_disabled, lpi_entry_pending, counter_freeze,
    output freeze, mse_bypass
  );
endinterface : rx_ctl_if

// *** freeze_decode.sv ***
`timescale 1ns/1ns
module freeze_decode (
  rx_ctl_if.decode ctl
);
  import phy_dsp_pkg::*;

  logic freeze_all;
  logic in_wait;

  always_comb begin
    in_wait = (ctl.seq_state == SEQ_LPI_WAIT);
    freeze_all = (ctl.rx_disabled && ctl.spare[SP_RXDIS_FREEZE_BIT])
      || (ctl.seq_state == SEQ_STEADY && ctl.spare[SP_STEADY_FREEZE_BIT]
          && ctl.lpi_entry_pending)
      || ctl.counter_freeze;
    ctl.mse_bypass = ctl.spare[SP_MSE_BYPASS_BIT]
      && (ctl.seq_state == SEQ_LPI_WAKE);
  end

  genvar i;
  generate
    for (i = 0; i < LOOP_COUNT; i = i + 1) begin : g_loop
      assign ctl.freeze[i] = freeze_all
        || (in_wait && ctl.spare[SP_WAIT_FREEZE_LSB + i]);
    end
  endgenerate

endmodule : freeze_decode

// *** phy_dsp_dac_config_regs.sv ***
`timescale 1ns/1ns
module phy_dsp_dac_config_regs #(
  parameter int unsigned TIMER_SHORT = phy_dsp_pkg::TIMER_SHORT_CYCLES,
  parameter int unsigned TIMER_LONG = phy_dsp_pkg::TIMER_LONG_CYCLES,
  // Revision indicator; the value is arbitrary.
  parameter logic REVISION_BIT = 1'b0
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_reset,
  // Register access
  input wire logic [15:0] i_reg_addr,
  input wire logic [15:0] i_reg_wdata,
  input wire logic i_reg_write,
  input wire logic i_reg_read,
  output logic [15:0] o_reg_rdata,
  output logic o_reg_rvalid,
  // Receive sequencer status
  input wire phy_dsp_pkg::seq_state_type i_seq_state,
  input wire logic i_receiver_disabled_flag,
  input wire logic i_lpi_entry_pending,
  input wire logic i_deq_iteration,
  input wire logic i_clock_output_pin_status,
  input wire logic [phy_dsp_pkg::KP_W-1:0] i_kp_gain_adaptive,
  input wire logic [phy_dsp_pkg::KF_W-1:0] i_kf_gain_adaptive,
  // Transmit symbol
  input wire phy_dsp_pkg::mlt3_type i_mlt3_symbol,
  output logic [phy_dsp_pkg::DAC_LEVEL_W-1:0] o_dac_level,
  // Receive DSP controls
  output logic o_rmii_rx_clk_sel,
  output logic [phy_dsp_pkg::LOOP_COUNT-1:0] o_loop_freeze,
  output logic o_mse_check_bypass,
  output logic [phy_dsp_pkg::TC_SEL_W-1:0] o_first_adapt_timer_select,
  output logic o_ffe_adapt_freeze,
  output logic [phy_dsp_pkg::CHECK_EN_W-1:0] o_deq_check_enable,
  output logic o_freqacc_clear,
  output logic o_dfe_coeff_reset,
  output logic [phy_dsp_pkg::CAGC_W-1:0] o_cagc_mapping,
  output logic o_deq_coeff_sel,
  output logic [phy_dsp_pkg::COEFF_W-1:0] o_coeff0_short,
  output logic [phy_dsp_pkg::COEFF_W-1:0] o_coeff0_long,
  output logic [phy_dsp_pkg::COEFF_W-1:0] o_coeff1_short,
  output logic [phy_dsp_pkg::KP_W-1:0] o_kp_gain,
  output logic [phy_dsp_pkg::KF_W-1:0] o_kf_gain,
  output logic o_kp_frozen,
  output logic o_kf_frozen,
  output logic o_pd_polarity_invert,
  output logic o_energy_input_sel,
  output logic o_precursor_metric_en
);
  import phy_dsp_pkg::*;

  // Maps an address to a register slot; slot 7 is unmapped.
  function automatic logic [2:0] reg_slot(input logic [15:0] addr);
    case (addr)
      SPARE_OFFSET: reg_slot = 3'h0;
      DAC0_OFFSET: reg_slot = 3'h1;
      DAC1_OFFSET: reg_slot = 3'h2;
      DSP0_OFFSET: reg_slot = 3'h3;
      DSP2_OFFSET: reg_slot = 3'h4;
      DSP4_OFFSET: reg_slot = 3'h5;
      DSP13_OFFSET: reg_slot = 3'h6;
      default: reg_slot = 3'h7;
    endcase
  endfunction : reg_slot

  logic [15:0] spare_reg, spare_next;
  logic [15:0] dac0_reg, dac0_next;
  logic [15:0] dac1_reg, dac1_next;
  logic [15:0] dsp0_reg, dsp0_next;
  logic [15:0] dsp2_reg, dsp2_next;
  logic [15:0] dsp4_reg, dsp4_next;
  logic [15:0] dsp13_reg, dsp13_next;
  logic [15:0] rdata_reg, rdata_next;
  logic rvalid_reg, rvalid_next;

  // Register file: writes keep only the writable bits, reads return zero elsewhere except spare pin status and revision bits.
  always_comb begin
    spare_next = spare_reg;
    dac0_next = dac0_reg;
    dac1_next = dac1_reg;
    dsp0_next = dsp0_reg;
    dsp2_next = dsp2_reg;
    dsp4_next = dsp4_reg;
    dsp13_next = dsp13_reg;
    if (i_reg_write) begin
      case (reg_slot(i_reg_addr))
        3'h0: spare_next = i_reg_wdata & SPARE_WMASK;
        3'h1: dac0_next = i_reg_wdata & DAC0_WMASK;
        3'h2: dac1_next = i_reg_wdata & DAC1_WMASK;
        3'h3: dsp0_next = i_reg_wdata & DSP0_WMASK;
        3'h4: dsp2_next = i_reg_wdata & DSP2_WMASK;
        3'h5: dsp4_next = i_reg_wdata & DSP4_WMASK;
        3'h6: dsp13_next = i_reg_wdata & DSP13_WMASK;
        default: ;
      endcase
    end
    rvalid_next = i_reg_read;
    rdata_next = rdata_reg;
    if (i_reg_read) begin
      case (reg_slot(i_reg_addr))
        3'h0: begin
          rdata_next = spare_reg;
          rdata_next[SP_REVISION_BIT] = REVISION_BIT;
          rdata_next[SP_PIN_STATUS_BIT] = i_clock_output_pin_status;
        end
        3'h1: rdata_next = dac0_reg;
        3'h2: rdata_next = dac1_reg;
        3'h3: rdata_next = dsp0_reg;
        3'h4: rdata_next = dsp2_reg;
        3'h5: rdata_next = dsp4_reg;
        3'h6: rdata_next = dsp13_reg;
        default: rdata_next = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      spare_reg <= SPARE_RESET;
      dac0_reg <= DAC0_RESET;
      dac1_reg <= DAC1_RESET;
      dsp0_reg <= DSP0_RESET;
      dsp2_reg <= DSP2_RESET;
      dsp4_reg <= DSP4_RESET;
      dsp13_reg <= DSP13_RESET;
      rdata_reg <= 16'h0000;
      rvalid_reg <= 1'b0;
    end else begin
      spare_reg <= spare_next;
      dac0_reg <= dac0_next;
      dac1_reg <= dac1_next;
      dsp0_reg <= dsp0_next;
      dsp2_reg <= dsp2_next;
      dsp4_reg <= dsp4_next;
      dsp13_reg <= dsp13_next;
      rdata_reg <= rdata_next;
      rvalid_reg <= rvalid_next;
    end
  end

  // Counter-based freeze over the low-power refresh cycle.
  cnt_state_type cnt_state_reg, cnt_state_next;
  logic [TIMER_W-1:0] count_reg, count_next;
  logic [TIMER_W-1:0] count_limit;
  logic in_refresh;

  always_comb begin
    in_refresh = (i_seq_state == SEQ_LPI_REFRESH);
    count_limit = spare_reg[SP_TIMER_LONG_BIT] ? TIMER_W'(TIMER_LONG - 1)
                                               : TIMER_W'(TIMER_SHORT - 1);
    cnt_state_next = cnt_state_reg;
    count_next = count_reg;
    case (cnt_state_reg)
      CNT_IDLE: begin
        if (in_refresh && spare_reg[SP_COUNT_FREEZE_BIT]) begin
          cnt_state_next = CNT_RUN;
          count_next = '0;
        end
      end
      CNT_RUN: begin
        if (!in_refresh) begin
          cnt_state_next = CNT_IDLE;
        end else if (count_reg == count_limit) begin
          cnt_state_next = CNT_DONE;
        end else begin
          count_next = count_reg + 1'b1;
        end
      end
      CNT_DONE: begin
        if (!in_refresh) begin
          cnt_state_next = CNT_IDLE;
        end
      end
      default: cnt_state_next = CNT_IDLE;
    endcase
  end

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      cnt_state_reg <= CNT_IDLE;
      count_reg <= '0;
    end else begin
      cnt_state_reg <= cnt_state_next;
      count_reg <= count_next;
    end
  end

  rx_ctl_if ctl ();
  assign ctl.spare = spare_reg;
  assign ctl.seq_state = i_seq_state;
  assign ctl.rx_disabled = i_receiver_disabled_flag;
  assign ctl.lpi_entry_pending = i_lpi_entry_pending;
  assign ctl.counter_freeze = (cnt_state_reg == CNT_RUN);

  freeze_decode u_freeze_decode (
    .ctl(ctl.decode)
  );

  // Registered datapath controls.
  logic [DAC_LEVEL_W-1:0] dac_reg, dac_next;
  logic [LOOP_COUNT-1:0] freeze_reg, freeze_next;
  logic mse_bypass_reg, mse_bypass_next;
  logic ffe_freeze_reg, ffe_freeze_next;
  logic [CHECK_EN_W-1:0] check_reg, check_next;
  logic freqacc_reg, freqacc_next;
  logic dfe_rst_reg, dfe_rst_next;
  logic [KP_W-1:0] kp_gain_reg, kp_gain_next;
  logic [KF_W-1:0] kf_gain_reg, kf_gain_next;
  logic kp_frozen_reg, kp_frozen_next;
  logic kf_frozen_reg, kf_frozen_next;

  always_comb begin
    case (i_mlt3_symbol)
      MLT3_MINUS: dac_next = dac0_reg[DAC_MINUS_LSB +: DAC_LEVEL_W];
      MLT3_ZERO: dac_next = dac0_reg[DAC_ZERO_LSB +: DAC_LEVEL_W];
      MLT3_PLUS: dac_next = dac1_reg[DAC_PLUS_LSB +: DAC_LEVEL_W];
      default: dac_next = '0;
    endcase
    freeze_next = ctl.freeze;
    mse_bypass_next = ctl.mse_bypass;
    ffe_freeze_next = ctl.freeze[LOOP_FFE]
      || (i_seq_state == SEQ_FFE1 && dsp0_reg[FIRST_FREEZE_BIT])
      || (i_seq_state == SEQ_FFE2 && dsp0_reg[SECOND_FREEZE_BIT])
      || (i_seq_state == SEQ_FFE3 && dsp0_reg[THIRD_FREEZE_BIT]);
    check_next = (i_seq_state == SEQ_DEQ_SWEEP)
      ? dsp0_reg[CHECK_EN_LSB +: CHECK_EN_W] : '0;
    freqacc_next = i_deq_iteration && dsp0_reg[FREQACC_CLR_BIT];
    dfe_rst_next = i_deq_iteration && dsp0_reg[DFE_RESET_BIT];
    kp_gain_next = dsp13_reg[KP_FORCE_EN_BIT]
      ? dsp13_reg[KP_VAL_LSB +: KP_W] : i_kp_gain_adaptive;
    kf_gain_next = dsp13_reg[KF_FORCE_EN_BIT]
      ? dsp13_reg[KF_VAL_LSB +: KF_W] : i_kf_gain_adaptive;
    kp_frozen_next = ctl.freeze[LOOP_KP]
      || (dsp13_reg[KP_FREEZE_EN_BIT] && dsp13_reg[KP_FREEZE_VAL_BIT]);
    kf_frozen_next = ctl.freeze[LOOP_KF]
      || (dsp13_reg[KF_FREEZE_EN_BIT] && dsp13_reg[KF_FREEZE_VAL_BIT]);
  end

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      dac_reg <= '0;
      freeze_reg <= '0;
      mse_bypass_reg <= 1'b0;
      ffe_freeze_reg <= 1'b0;
      check_reg <= '0;
      freqacc_reg <= 1'b0;
      dfe_rst_reg <= 1'b0;
      kp_gain_reg <= '0;
      kf_gain_reg <= '0;
      kp_frozen_reg <= 1'b0;
      kf_frozen_reg <= 1'b0;
    end else begin
      dac_reg <= dac_next;
      freeze_reg <= freeze_next;
      mse_bypass_reg <= mse_bypass_next;
      ffe_freeze_reg <= ffe_freeze_next;
      check_reg <= check_next;
      freqacc_reg <= freqacc_next;
      dfe_rst_reg <= dfe_rst_next;
      kp_gain_reg <= kp_gain_next;
      kf_gain_reg <= kf_gain_next;
      kp_frozen_reg <= kp_frozen_next;
      kf_frozen_reg <= kf_frozen_next;
    end
  end

  assign o_reg_rdata = rdata_reg;
  assign o_reg_rvalid = rvalid_reg;
  assign o_dac_level = dac_reg;
  assign o_loop_freeze = freeze_reg;
  assign o_mse_check_bypass = mse_bypass_reg;
  assign o_ffe_adapt_freeze = ffe_freeze_reg;
  assign o_deq_check_enable = check_reg;
  assign o_freqacc_clear = freqacc_reg;
  assign o_dfe_coeff_reset = dfe_rst_reg;
  assign o_kp_gain = kp_gain_reg;
  assign o_kf_gain = kf_gain_reg;
  assign o_kp_frozen = kp_frozen_reg;
  assign o_kf_frozen = kf_frozen_reg;
  assign o_rmii_rx_clk_sel = spare_reg[SP_RMII_CLK_SEL_BIT];
  assign o_first_adapt_timer_select = dsp0_reg[TC_SEL_LSB +: TC_SEL_W];
  // The undefined mapping code 3 falls back to the default mapping.
  assign o_cagc_mapping = (dsp2_reg[CAGC_LSB +: CAGC_W] == 2'h3)
    ? 2'h0 : dsp2_reg[CAGC_LSB +: CAGC_W];
  assign o_deq_coeff_sel = dsp2_reg[COEFF_SEL_BIT];
  assign o_coeff0_short = dsp2_reg[COEFF0_SHORT_LSB +: COEFF_W];
  assign o_coeff0_long = dsp4_reg[COEFF0_LONG_LSB +: COEFF_W];
  assign o_coeff1_short = dsp4_reg[COEFF1_SHORT_LSB +: COEFF_W];
  assign o_pd_polarity_invert = dsp13_reg[PD_POL_BIT];
  assign o_energy_input_sel = dsp13_reg[ENERGY_SEL_BIT];
  assign o_precursor_metric_en = dsp13_reg[PRECURSOR_EN_BIT];

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_reset);

  sequence refresh_entry_s;
    in_refresh && spare_reg[SP_COUNT_FREEZE_BIT] && cnt_state_reg == CNT_IDLE;
  endsequence

  sequence freeze_run_s;
    cnt_state_reg == CNT_RUN ##1 (&o_loop_freeze);
  endsequence

  rmii_clk_sel_a: assert property (
    i_reg_write && i_reg_addr == SPARE_OFFSET |=> o_rmii_rx_clk_sel == $past(i_reg_wdata[2]))
    else $error("RMII clock select did not follow spare write");
  rxdis_freeze_a: assert property (
    i_receiver_disabled_flag && spare_reg[SP_RXDIS_FREEZE_BIT] |=> &o_loop_freeze)
    else $error("Loops not frozen while receiver disabled");
  mse_bypass_a: assert property (
    i_seq_state == SEQ_LPI_WAKE && spare_reg[SP_MSE_BYPASS_BIT] |=> o_mse_check_bypass)
    else $error("MSE bypass mismatch");
  mse_bypass_set_a: assert property (
    i_seq_state != SEQ_LPI_WAKE |=> !o_mse_check_bypass)
    else $error("MSE check bypassed outside wake state");
  steady_freeze_a: assert property (
    i_seq_state == SEQ_STEADY && spare_reg[SP_STEADY_FREEZE_BIT] && i_lpi_entry_pending
    |=> &o_loop_freeze)
    else $error("Steady_operating_state freeze missing before low-power entry");
  refresh_freeze_a: assert property (
    refresh_entry_s |=> freeze_run_s)
    else $error("Refresh counter freeze did not start");
  refresh_bound_a: assert property (
    cnt_state_reg == CNT_RUN |-> count_reg <= count_limit)
    else $error("Refresh freeze counter overran its limit");
  wait_freeze_a: assert property (
    i_seq_state == SEQ_LPI_WAIT && spare_reg[SP_WAIT_FREEZE_LSB + LOOP_DFE]
    |=> o_loop_freeze[LOOP_DFE])
    else $error("Wait state loop freeze missing");
  pin_status_a: assert property (
    i_reg_read && i_reg_addr == SPARE_OFFSET |=> o_reg_rdata[0] == $past(i_clock_output_pin_status))
    else $error("Pin status bit not reported");
  dac_minus_a: assert property (
    i_mlt3_symbol == MLT3_MINUS |=> o_dac_level == $past(dac0_reg[11:6]))
    else $error("Minus-one DAC level wrong");
  dac_plus_a: assert property (
    i_mlt3_symbol == MLT3_PLUS |=> o_dac_level == $past(dac1_reg[5:0]))
    else $error("Plus-one DAC level wrong");
  ffe_stage_a: assert property (
    i_seq_state == SEQ_FFE2 && dsp0_reg[SECOND_FREEZE_BIT] |=> o_ffe_adapt_freeze)
    else $error("Second adaptation state not frozen");
  deq_check_a: assert property (
    i_seq_state != SEQ_DEQ_SWEEP |=> o_deq_check_enable == 3'h0)
    else $error("Threshold checks enabled outside sweep");
  dfe_reset_a: assert property (
    i_deq_iteration && dsp0_reg[DFE_RESET_BIT] && !$past(i_deq_iteration)
    |=> o_dfe_coeff_reset
    ##1 (o_dfe_coeff_reset == ($past(i_deq_iteration) && $past(dsp0_reg[DFE_RESET_BIT]))))
    else $error("DFE reset pulse wrong");
  kp_force_a: assert property (
    dsp13_reg[KP_FORCE_EN_BIT] |=> o_kp_gain == $past(dsp13_reg[13:11]))
    else $error("Proportional gain not forced");
  kf_freeze_a: assert property (
    dsp13_reg[KF_FREEZE_EN_BIT] && dsp13_reg[KF_FREEZE_VAL_BIT] |=> o_kf_frozen)
    else $error("Integral arm not frozen");
  reserved_zero_a: assert property (
    i_reg_read && i_reg_addr == DAC1_OFFSET |=> o_reg_rdata[15:6] == 10'h000)
    else $error("Reserved bits read nonzero");

endmodule : phy_dsp_dac_config_regs

// *** mgmt_host.sv ***
`timescale 1ns/1ns
module mgmt_host (
  input wire logic i_clk,
  output logic [15:0] o_addr,
  output logic [15:0] o_wdata,
  output logic o_write,
  output logic o_read
);
  initial begin
    o_addr = 16'h0000;
    o_wdata = 16'h0000;
    o_write = 1'b0;
    o_read = 1'b0;
  end
  // Strobes last one cycle; released data is inverted so stale values never look valid.
  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    @(negedge i_clk);
    o_addr = a;
    o_wdata = d;
    o_write = 1'b1;
    @(negedge i_clk);
    o_write = 1'b0;
    o_wdata = ~d;
  endtask : wr
  task automatic rd(input logic [15:0] a);
    @(negedge i_clk);
    o_addr = a;
    o_read = 1'b1;
    @(negedge i_clk);
    o_read = 1'b0;
  endtask : rd
endmodule : mgmt_host

// *** phy_dsp_dac_config_regs_tb.sv ***
`timescale 1ns/1ns
module phy_dsp_dac_config_regs_tb;
  import phy_dsp_pkg::*;
  logic i_clk = 1'b0;
  logic i_reset = 1'b1;
  logic [15:0] addr, wdata, rdata, v;
  logic wr, rd, rvalid, pin_st, rmii, kpf;
  logic [5:0] lvl, frz, m, z, p;
  logic [2:0] kp;
  logic rxdis, lpi_pend, deq_it, mse_b, ffe_f, fqc, dfer, cdsel, kff, pdp, ensel, pre;
  logic [2:0] tcs, chk;
  logic [1:0] cagc;
  logic [7:0] c0s, c0l, c1s;
  logic [3:0] kfg;
  int n;
  seq_state_type st;
  mlt3_type sym;
  logic [15:0] exp_q[$];
  logic [15:0] ad[7] = '{SPARE_OFFSET, DAC0_OFFSET, DAC1_OFFSET, DSP0_OFFSET, DSP2_OFFSET,
    DSP4_OFFSET, DSP13_OFFSET};
  logic [15:0] rs[7] = '{SPARE_RESET, DAC0_RESET, DAC1_RESET, DSP0_RESET, DSP2_RESET,
    DSP4_RESET, DSP13_RESET};
  logic [15:0] mk[7] = '{SPARE_WMASK, DAC0_WMASK, DAC1_WMASK, DSP0_WMASK, DSP2_WMASK,
    DSP4_WMASK, DSP13_WMASK};
  int n_fail = 0;
  int tests_run = 0;
  always #2 i_clk = ~i_clk;
  mgmt_host host (.i_clk(i_clk), .o_addr(addr), .o_wdata(wdata), .o_write(wr), .o_read(rd));
  phy_dsp_dac_config_regs #(.TIMER_SHORT(8), .TIMER_LONG(12)) dut (
    .i_clk(i_clk), .i_reset(i_reset), .i_reg_addr(addr), .i_reg_wdata(wdata),
    .i_reg_write(wr), .i_reg_read(rd), .o_reg_rdata(rdata), .o_reg_rvalid(rvalid),
    .i_seq_state(st), .i_receiver_disabled_flag(rxdis), .i_lpi_entry_pending(lpi_pend),
    .i_deq_iteration(deq_it), .i_clock_output_pin_status(pin_st),
    .i_kp_gain_adaptive(3'h5), .i_kf_gain_adaptive(4'h3), .i_mlt3_symbol(sym),
    .o_dac_level(lvl), .o_rmii_rx_clk_sel(rmii), .o_loop_freeze(frz),
    .o_mse_check_bypass(mse_b), .o_first_adapt_timer_select(tcs), .o_ffe_adapt_freeze(ffe_f),
    .o_deq_check_enable(chk), .o_freqacc_clear(fqc), .o_dfe_coeff_reset(dfer),
    .o_cagc_mapping(cagc), .o_deq_coeff_sel(cdsel), .o_coeff0_short(c0s),
    .o_coeff0_long(c0l), .o_coeff1_short(c1s), .o_kp_gain(kp), .o_kf_gain(kfg),
    .o_kp_frozen(kpf), .o_kf_frozen(kff), .o_pd_polarity_invert(pdp),
    .o_energy_input_sel(ensel), .o_precursor_metric_en(pre));
  task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask : cmp
  task automatic rdx(input logic [15:0] a, input logic [15:0] e);
    exp_q.push_back(e);
    host.rd(a);
  endtask : rdx
  task automatic finish_test;
    $display("checks %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : finish_test
  // Read data is checked in the cycle its valid pulse stands.
  always @(negedge i_clk) begin
    if (rvalid === 1'b1) begin
      if (exp_q.size() == 0) begin
        cmp(rdata, ~rdata);
      end else begin
        cmp(rdata, exp_q.pop_front());
      end
    end
  end
  initial begin
    #20000;
    n_fail++;
    finish_test();
  end
  initial begin
    st = SEQ_IDLE;
    sym = MLT3_ZERO;
    pin_st = 1'b0;
    rxdis = 1'b0;
    lpi_pend = 1'b0;
    deq_it = 1'b0;
    v = $urandom(59);
    repeat (10) @(negedge i_clk);
    i_reset = 1'b0;
    for (int i = 0; i < 7; i++) begin
      rdx(ad[i], rs[i]);
    end
    cmp({13'h0, tcs}, 16'h0004);
    cmp({c0s, c1s}, 16'hFEF8);
    cmp({8'h0, c0l}, 16'h0006);
    cmp({15'h0, pre}, 16'h0001);
    for (int i = 0; i < 7; i++) begin
      v = 16'($urandom());
      host.wr(ad[i], v);
      rdx(ad[i], v & mk[i]);
    end
    rdx(16'h0309, 16'h0000);
    host.wr(SPARE_OFFSET, 16'hFC04);
    pin_st = 1'b1;
    rdx(SPARE_OFFSET, 16'hFC05);
    cmp({15'h0, rmii}, 16'h0001);
    st = SEQ_LPI_WAIT;
    repeat (2) @(negedge i_clk);
    cmp({10'h0, frz}, 16'h003F);
    for (int k = 0; k < 6; k++) begin
      host.wr(SPARE_OFFSET, 16'h0400 << k);
      @(negedge i_clk);
      cmp({10'h0, frz}, 16'h0001 << k);
    end
    st = SEQ_IDLE;
    m = 6'($urandom());
    z = 6'($urandom());
    p = 6'($urandom());
    host.wr(DAC0_OFFSET, {4'h0, m, z});
    host.wr(DAC1_OFFSET, {10'h000, p});
    sym = MLT3_MINUS;
    @(negedge i_clk);
    cmp({10'h0, lvl}, {10'h0, m});
    sym = MLT3_ZERO;
    @(negedge i_clk);
    cmp({10'h0, lvl}, {10'h0, z});
    sym = MLT3_PLUS;
    @(negedge i_clk);
    cmp({10'h0, lvl}, {10'h0, p});
    // Force the proportional gain to 6 and freeze that arm.
    host.wr(DSP13_OFFSET, 16'hB061);
    @(negedge i_clk);
    cmp({13'h0, kp}, 16'h0006);
    cmp({15'h0, kpf}, 16'h0001);
    host.wr(DSP13_OFFSET, 16'h0041);
    @(negedge i_clk);
    cmp({13'h0, kp}, 16'h0005);
    cmp({15'h0, kpf}, 16'h0000);
    // Whole-bank freezes from the receiver and steady conditions, and the wake-state MSE bypass.
    host.wr(SPARE_OFFSET, 16'h0070);
    st = SEQ_LPI_WAKE;
    @(negedge i_clk);
    cmp({15'h0, mse_b}, 16'h0001);
    rxdis = 1'b1;
    st = SEQ_IDLE;
    @(negedge i_clk);
    cmp({10'h0, frz}, 16'h003F);
    cmp({15'h0, mse_b}, 16'h0000);
    rxdis = 1'b0;
    st = SEQ_STEADY;
    lpi_pend = 1'b1;
    @(negedge i_clk);
    cmp({10'h0, frz}, 16'h003F);
    lpi_pend = 1'b0;
    @(negedge i_clk);
    cmp({10'h0, frz}, 16'h0000);
    // Counted refresh freeze with the short and then the long timer.
    for (int t = 0; t < 2; t++) begin
      st = SEQ_IDLE;
      host.wr(SPARE_OFFSET, 16'h0080 | (16'(t) << 8));
      st = SEQ_LPI_REFRESH;
      n = 0;
      repeat (20) begin
        @(negedge i_clk);
        if (frz === 6'h3F) begin
          n++;
        end
      end
      cmp(16'(n), (t == 1) ? 16'h000C : 16'h0008);
    end
    st = SEQ_IDLE;
    host.wr(DSP0_OFFSET, 16'h03B7);
    cmp({13'h0, tcs}, 16'h0003);
    st = SEQ_FFE1;
    @(negedge i_clk);
    cmp({15'h0, ffe_f}, 16'h0001);
    st = SEQ_FFE2;
    @(negedge i_clk);
    cmp({15'h0, ffe_f}, 16'h0000);
    st = SEQ_FFE3;
    @(negedge i_clk);
    cmp({15'h0, ffe_f}, 16'h0001);
    st = SEQ_DEQ_SWEEP;
    deq_it = 1'b1;
    @(negedge i_clk);
    cmp({13'h0, chk}, 16'h0005);
    cmp({14'h0, fqc, dfer}, 16'h0003);
    deq_it = 1'b0;
    @(negedge i_clk);
    cmp({14'h0, fqc, dfer}, 16'h0000);
    st = SEQ_IDLE;
    host.wr(DSP2_OFFSET, 16'hE000);
    cmp({14'h0, cagc}, 16'h0000);
    cmp({15'h0, cdsel}, 16'h0001);
    v = 16'($urandom());
    host.wr(DSP2_OFFSET, {7'h40, v[7:0], 1'b0});
    cmp({14'h0, cagc}, 16'h0002);
    cmp({15'h0, cdsel}, 16'h0000);
    cmp({8'h0, c0s}, {8'h0, v[7:0]});
    host.wr(DSP4_OFFSET, v);
    cmp({c0l, c1s}, v);
    host.wr(DSP13_OFFSET, 16'h451E);
    @(negedge i_clk);
    cmp({12'h0, kfg}, 16'h000A);
    cmp({15'h0, kff}, 16'h0001);
    cmp({13'h0, pdp, ensel, pre}, 16'h0006);
    // A second reset in mid-run brings back the reset values.
    i_reset = 1'b1;
    repeat (2) @(negedge i_clk);
    i_reset = 1'b0;
    rdx(DAC1_OFFSET, 16'h0020);
    cmp({15'h0, pre}, 16'h0001);
    repeat (3) @(negedge i_clk);
    finish_test();
  end
endmodule : phy_dsp_dac_config_regs_tb
